//--- sim/tb.sv
/*
 * tb: self-checking bench of pads_select, driven over ahb-lite.
 * assumes: a single slave whose hreadyout is the bus hready, and
 * has_port_c left at its default of 1.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk      = 1'b0;
    logic        hresetn   = 1'b0;
    logic        hsel      = 1'b0;
    logic        hwrite    = 1'b0;
    logic [31:0] haddr     = 32'h0;
    logic [31:0] hwdata    = 32'h0;
    logic [1:0]  htrans    = 2'h0;
    logic [2:0]  hsize     = pads_pkg::hsize_word;
    logic [15:0] pin_in_a  = 16'h0;
    logic [15:0] pin_in_b  = 16'h0;
    logic [15:0] pin_in_c  = 16'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hreadyout;
    logic        hresp;
    logic [15:0] mode_a;
    logic [15:0] mode_b;
    logic [15:0] mode_c;
    logic [15:0] dir;
    logic [11:0] offs [3] = '{pads_pkg::off_port_a_sel, pads_pkg::off_port_b_sel, pads_pkg::off_port_c_sel};
    logic [15:0] masks [3] = '{pads_pkg::port_a_mask, pads_pkg::port_b_mask, pads_pkg::port_c_mask};
    int          bad_count = 0;
    int          tests_run = 0;

    always #5 hclk = ~hclk;

    pads_select i_pads_select (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pin_in_a(pin_in_a), .pin_in_b(pin_in_b), .pin_in_c(pin_in_c),
        .analog_mode_a(mode_a), .analog_mode_b(mode_b), .analog_mode_c(mode_c), .direction_control(dir));

    // =====================================================================
    // bus cycles and comparison
    // =====================================================================
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= pads_pkg::htrans_nonseq;
        haddr  <= {20'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask : xfer

    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task summarize;
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // =====================================================================
    // tests
    // =====================================================================
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        check({16'h0, mode_b}, {16'h0, pads_pkg::port_b_reset});
        check({16'h0, dir}, 32'h0000ffff);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, offs[i], 32'h0, rd);
            check(rd, {16'h0, masks[i]});
            xfer(1'b1, offs[i], 32'hffffffff, rd);
            xfer(1'b0, offs[i], 32'h0, rd);
            check(rd, {16'h0, masks[i]});
            xfer(1'b1, offs[i], 32'h0, rd);
            xfer(1'b0, offs[i], 32'h0, rd);
            check(rd, 32'h0);
        end
        check({mode_a, mode_b}, 32'h0);
        check({16'h0, mode_c}, 32'h0);
        check({31'h0, hresp}, 32'h0);
        xfer(1'b0, pads_pkg::off_direction, 32'h0, rd);
        check(rd, 32'h0000ffff);
        // upper eight pins become digital outputs with their select already clear
        xfer(1'b1, pads_pkg::off_direction, 32'h000000ff, rd);
        @(posedge hclk);
        check({16'h0, dir}, 32'h000000ff);
        xfer(1'b1, pads_pkg::off_port_a_sel, 32'h00000005, rd);
        xfer(1'b1, pads_pkg::off_port_b_sel, 32'h00000240, rd);
        @(posedge hclk);
        check({mode_a, mode_b}, 32'h00050240);
        pin_in_a <= 16'h00ff;
        pin_in_b <= 16'h0f4f;
        repeat (4) @(posedge hclk);
        // analog pins read low, digital pins pass through
        xfer(1'b0, pads_pkg::off_pin_value, 32'h0, rd);
        check(rd, {16'h0f4f & ~16'h0240, 16'h00ff & ~16'h0005});
        xfer(1'b1, pads_pkg::off_port_c_sel, 32'h00000002, rd);
        pin_in_c <= 16'h00f7;
        repeat (4) @(posedge hclk);
        xfer(1'b0, pads_pkg::off_pin_value_c, 32'h0, rd);
        check(rd, 32'h000000f5);
        xfer(1'b1, 12'h020, 32'hffffffff, rd);
        xfer(1'b0, 12'h020, 32'h0, rd);
        check(rd, 32'h0);
        // reset in mid-run brings every register back to its reset value
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        check({mode_a, mode_b}, {pads_pkg::port_a_reset, pads_pkg::port_b_reset});
        check({mode_c, dir}, {pads_pkg::port_c_reset, pads_pkg::dir_reset});
        // the pin synchronisers refill after reset
        repeat (4) @(posedge hclk);
        xfer(1'b0, pads_pkg::off_pin_value, 32'h0, rd);
        check(rd, 32'h0d0000f0);
        summarize();
    end

    initial begin
        repeat (2000) @(posedge hclk);
        bad_count++;
        summarize();
    end
endmodule : tb

//--- src/pads_pkg.sv
/*
 * pads_pkg: register map, field masks and reset values of the pin
 * analog/digital select block.
 * assumes: AHB-Lite with 32-bit data, one aligned word per register.
 */
package pads_pkg;

    // =====================================================================
    // register map
    // =====================================================================
    localparam logic [11:0] off_port_a_sel  = 12'h000;
    localparam logic [11:0] off_port_b_sel  = 12'h004;
    localparam logic [11:0] off_port_c_sel  = 12'h008;
    localparam logic [11:0] off_direction   = 12'h00c;
    localparam logic [11:0] off_pin_value   = 12'h010;
    localparam logic [11:0] off_pin_value_c = 12'h014;

    // =====================================================================
    // implemented select bits and reset values
    // =====================================================================
    localparam logic [15:0] port_a_mask  = 16'h000f;
    localparam logic [15:0] port_b_mask  = 16'hf24f;
    localparam logic [15:0] port_c_mask  = 16'h0007;
    localparam logic [15:0] port_a_reset = 16'h000f;
    localparam logic [15:0] port_b_reset = 16'hf24f;
    localparam logic [15:0] port_c_reset = 16'h0007;
    localparam logic [15:0] dir_reset    = 16'hffff;

    localparam logic [1:0]  htrans_nonseq = 2'h2;
    localparam logic [2:0]  hsize_word    = 3'h2;

    typedef struct packed {
        logic [15:0] sel;
        logic [15:0] dir;
    } pads_port_cfg_t;

endpackage : pads_pkg

//--- src/pads_select.sv
/*
 * pads_select: analog/digital pin function select for ports a, b and c.
 * assumes: one AHB-Lite master, single word transfers; pin inputs come
 * from pads outside the hclk domain.
 */
// The AHB-Lite register port and the register offsets are this design's own decisions.
// How it works
// R1 - a pin is analog when its select bit and its direction bit are both 1, and software keeps select at 1 then; the code uses select alone.
// R2 - a digital input has select 0 and direction 1, and software waits a cycle before trusting its read value; the code's synchroniser has two stages.
// R3 - a digital output has select 0 and direction 0, after software has turned off any analog output there.
// R4 - a set select bit gives analog mode and blocks the digital read, a clear bit gives digital mode with read on.
// R5 - port a select has read/write bits 3 to 0 reset to 1, with bits 15 to 4 reading zero.
// R6 - port b select has read/write bits 15 to 12, 9, 6 and 3 to 0 reset to 1, the others reading zero.
// R7 - port c select has read/write bits 2 to 0 reset to 1, with bits 15 to 3 reading zero.
// R8 - a parameter drops port c and its select register for the small package.
// R9 - reading the pin values returns low for every pin set up as an analog input.
// R10 - direction 1 makes a pin an input and every pin is an input after reset.
// R11 - writes to unimplemented select positions are dropped so those bits always read zero.
module pads_select #(
    parameter bit has_port_c = 1'b1
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [15:0] pin_in_a,
    input  wire logic [15:0] pin_in_b,
    input  wire logic [15:0] pin_in_c,
    output logic      [15:0] analog_mode_a,
    output logic      [15:0] analog_mode_b,
    output logic      [15:0] analog_mode_c,
    output logic      [15:0] direction_control
);

    // =====================================================================
    // bus address phase capture
    // =====================================================================
    logic        wr_pend;
    logic [11:0] wr_addr;
    logic        next_wr_pend;
    logic [11:0] next_wr_addr;
    logic        rd_now;

    always_comb begin
        next_wr_pend = hsel && hready && htrans == pads_pkg::htrans_nonseq && hwrite;
        next_wr_addr = haddr[11:0];
        rd_now       = hsel && hready && htrans == pads_pkg::htrans_nonseq && !hwrite;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
        end
    end

    // zero wait states: every transfer ends with its data phase
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // =====================================================================
    // select and direction registers
    // =====================================================================
    pads_pkg::pads_port_cfg_t cfg_a;
    pads_pkg::pads_port_cfg_t next_cfg_a;
    logic [15:0] sel_b;
    logic [15:0] sel_c;
    logic [15:0] next_sel_b;
    logic [15:0] next_sel_c;
    logic [15:0] c_mask;

    always_comb begin
        c_mask     = has_port_c ? pads_pkg::port_c_mask : 16'h0000;  // see R8
        next_cfg_a = cfg_a;
        next_sel_b = sel_b;
        next_sel_c = sel_c;
        if (wr_pend) begin
            case (wr_addr)
                pads_pkg::off_port_a_sel: next_cfg_a.sel = hwdata[15:0] & pads_pkg::port_a_mask;  // see R5 see R11
                pads_pkg::off_port_b_sel: next_sel_b = hwdata[15:0] & pads_pkg::port_b_mask;      // see R6 see R11
                pads_pkg::off_port_c_sel: next_sel_c = hwdata[15:0] & c_mask;                     // see R7 see R11
                pads_pkg::off_direction:  next_cfg_a.dir = hwdata[15:0];                          // see R10
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_a.sel <= pads_pkg::port_a_reset;
            cfg_a.dir <= pads_pkg::dir_reset;  // see R10
            sel_b     <= pads_pkg::port_b_reset;
            sel_c     <= has_port_c ? pads_pkg::port_c_reset : 16'h0000;
        end else begin
            cfg_a <= next_cfg_a;
            sel_b <= next_sel_b;
            sel_c <= next_sel_c;
        end
    end

    assign analog_mode_a     = cfg_a.sel;  // see R1 see R4
    assign analog_mode_b     = sel_b;      // see R1 see R4
    assign analog_mode_c     = sel_c;      // see R1 see R4
    assign direction_control = cfg_a.dir;

    // =====================================================================
    // pin synchronisers and read path
    // =====================================================================
    logic [47:0] pin_meta;
    logic [47:0] pin_sync;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta <= 48'h0;
            pin_sync <= 48'h0;
        end else begin
            pin_meta <= {pin_in_c, pin_in_b, pin_in_a};
            pin_sync <= pin_meta;
        end
    end

    // analog pins read low, whatever the pad shows
    function automatic logic [15:0] port_read(input logic [15:0] pins, input logic [15:0] sel);
        port_read = pins & ~sel;  // see R4 see R9
    endfunction : port_read

    // =====================================================================
    // register read mux
    // =====================================================================
    logic [31:0] rd_value;
    logic [31:0] next_hrdata;
    logic [15:0] pin_c_read;

    always_comb begin
        // port c pins read zero when the port is not fitted
        pin_c_read = has_port_c ? port_read(pin_sync[47:32], sel_c) : 16'h0000;  // see R8 see R9
        case (haddr[11:0])
            pads_pkg::off_port_a_sel: rd_value = {16'h0000, cfg_a.sel};
            pads_pkg::off_port_b_sel: rd_value = {16'h0000, sel_b};
            pads_pkg::off_port_c_sel: rd_value = {16'h0000, sel_c};
            pads_pkg::off_direction:  rd_value = {16'h0000, cfg_a.dir};
            pads_pkg::off_pin_value:  rd_value = {port_read(pin_sync[31:16], sel_b),
                                                  port_read(pin_sync[15:0], cfg_a.sel)};
            pads_pkg::off_pin_value_c: rd_value = {16'h0000, pin_c_read};
            default:                  rd_value = 32'h0000_0000;
        endcase
        next_hrdata = rd_now ? rd_value : hrdata;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= next_hrdata;
        end
    end

    // =====================================================================
    // register checks
    // =====================================================================
    a_unimpl_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R5
        (cfg_a.sel & ~pads_pkg::port_a_mask) == 16'h0000)
        else $error("port a spare bits set");
    b_unimpl_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R6
        (sel_b & ~pads_pkg::port_b_mask) == 16'h0000)
        else $error("port b spare bits set");
    c_unimpl_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R7 see R8
        (sel_c & ~c_mask) == 16'h0000)
        else $error("port c spare bits set");
    sel_a_write_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R5 see R11
        wr_pend && wr_addr == pads_pkg::off_port_a_sel
        |=> cfg_a.sel == ($past(hwdata[15:0]) & pads_pkg::port_a_mask))
        else $error("port a write lost");
    sel_write_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R6 see R11
        wr_pend && wr_addr == pads_pkg::off_port_b_sel
        |=> sel_b == ($past(hwdata[15:0]) & pads_pkg::port_b_mask))
        else $error("port b write lost");
    sel_c_write_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R7 see R11
        wr_pend && wr_addr == pads_pkg::off_port_c_sel
        |=> sel_c == ($past(hwdata[15:0]) & c_mask))
        else $error("port c write lost");
    dir_write_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R10
        wr_pend && wr_addr == pads_pkg::off_direction
        |=> cfg_a.dir == $past(hwdata[15:0]))
        else $error("direction write lost");
    hold_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R4
        !wr_pend |=> $stable(sel_b) && $stable(cfg_a.sel))
        else $error("select changed without write");
    c_sel_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R7
        !wr_pend |=> $stable(sel_c))
        else $error("port c select changed without write");
    dir_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R10
        !wr_pend |=> $stable(cfg_a.dir))
        else $error("direction changed without write");

    // =====================================================================
    // read path checks
    // =====================================================================
    analog_read_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R1 see R9
        rd_now && haddr[11:0] == pads_pkg::off_pin_value && !wr_pend
        |=> (hrdata[15:0] & cfg_a.sel) == 16'h0000)
        else $error("analog pin read high");
    b_analog_read_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R9
        rd_now && haddr[11:0] == pads_pkg::off_pin_value && !wr_pend
        |=> (hrdata[31:16] & sel_b) == 16'h0000)
        else $error("port b analog pin read high");
    c_analog_read_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R8 see R9
        rd_now && haddr[11:0] == pads_pkg::off_pin_value_c && !wr_pend
        |=> (hrdata[15:0] & sel_c) == 16'h0000)
        else $error("port c analog pin read high");
    upper_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R5 see R6 see R7
        rd_now && haddr[11:0] != pads_pkg::off_pin_value |=> hrdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    dir_read_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R10
        rd_now && haddr[11:0] == pads_pkg::off_direction |=> hrdata == {16'h0000, $past(cfg_a.dir)})
        else $error("direction read wrong");
    read_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)  // see R4
        !rd_now |=> $stable(hrdata))
        else $error("read data moved");

endmodule : pads_select
